/* File: dv/rtu_master_model.sv */
// Purpose : behavioural line master for the rtu slave framer bench
// Assumes : DIV clocks per bit, line idle high
// Notes   : reply characters land in rx_q; framing faults are counted in frame_bad
module rtu_master_model #(
  parameter int DIV = 16
) (
  input  wire logic mclk,
  output logic      rxd_pin,
  input  wire logic txd_pin,
  input  wire logic tx_en,
  input  wire logic par_on,
  input  wire logic par_odd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_q[$];
  int         frame_bad = 0;
  initial rxd_pin = 1'b1;

  // ----------------------------------------
  // crc and transmit
  // ----------------------------------------
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] a;
    a = 16'hffff;
    foreach (b[i])
    begin
      a = a ^ {8'h00, b[i]};
      for (int j = 0; j < 8; j++)
        a = a[0] ? ((a >> 1) ^ 16'ha001) : (a >> 1);
    end
    return a;
  endfunction : crc16

  task automatic put_bit(input logic v);
    #1 rxd_pin = v;
    repeat (DIV) @(posedge mclk);
  endtask : put_bit

  // characters go back to back, so no gap comes near the end-of-packet idle time
  task automatic send_pkt(input logic [7:0] p[$], input bit bad);
    logic [15:0] c;
    c = crc16(p) ^ {15'h0000, bad};
    p.push_back(c[7:0]);
    p.push_back(c[15:8]);
    @(posedge mclk);
    foreach (p[i])
    begin
      put_bit(1'b0);
      for (int j = 0; j < 8; j++)
        put_bit(p[i][j]);
      if (par_on)
        put_bit(^p[i] ^ par_odd);
      put_bit(1'b1);
    end
  endtask : send_pkt

  // ----------------------------------------
  // reply capture
  // ----------------------------------------
  always @(negedge txd_pin)
    if (tx_en === 1'b1)
    begin : rx_char
      logic [7:0] b;
      repeat (DIV / 2) @(posedge mclk);
      for (int j = 0; j < 8; j++)
      begin
        repeat (DIV) @(posedge mclk);
        b[j] = txd_pin;
      end
      if (par_on)
      begin
        repeat (DIV) @(posedge mclk);
        if (txd_pin !== (^b ^ par_odd))
          frame_bad++;
      end
      repeat (DIV) @(posedge mclk);
      if (txd_pin !== 1'b1)
        frame_bad++;
      rx_q.push_back(b);
    end
endmodule : rtu_master_model

/* File: dv/rtu_slave_link_framer_bench.sv */
// Purpose : self-checking bench for the rtu slave framer
// Assumes : CLK_HZ lowered so baud_sel 8 gives 16 clocks per bit
// Notes   : replies are compared byte by byte, crc included
module rtu_slave_link_framer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rtu_pkg::*;
  localparam int DIV = 16;
  typedef struct packed {logic [71:0] req; logic [3:0] n; logic fp; logic [7:0] exc; logic cmd;} rtu_row_t;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        rxd_pin, txd_pin, tx_en, rd_valid, word_ready, cmd_valid;
  logic        word_valid = 1'b0;
  logic [15:0] word_data = 16'h0000;
  logic [3:0]  stall = 4'h0;
  logic [15:0] wq[$];
  rtu_cfg_t    cfg;
  rtu_rdreq_t  rd_req, last_rd;
  rtu_cmd_t    cmd, last_cmd;
  int          n_fail = 0;
  int          comparisons = 0;
  int          n_cmd = 0;
  // exc: 00 echo, ff silent, other values are the expected exception code
  rtu_row_t    rows [10] = '{
    '{72'h11050001ff00000000, 4'h6, 1'b0, 8'h00, 1'b1}, '{72'h1106405100c8000000, 4'h6, 1'b0, 8'h00, 1'b1},
    '{72'h1110405100010200c8, 4'h9, 1'b0, 8'h00, 1'b1}, '{72'h113900000000000000, 4'h6, 1'b0, 8'h01, 1'b0},
    '{72'h22050001ff00000000, 4'h6, 1'b0, 8'hff, 1'b0}, '{72'h00050001ff00000000, 4'h6, 1'b0, 8'hff, 1'b1},
    '{72'h0006405100c8000000, 4'h6, 1'b0, 8'hff, 1'b0}, '{72'h3306405100c8000000, 4'h6, 1'b1, 8'h00, 1'b1},
    '{72'h110340500000000000, 4'h6, 1'b0, 8'h03, 1'b0}, '{72'h11034050007e000000, 4'h6, 1'b0, 8'h03, 1'b0}};

  always #2 mclk = ~mclk;

  rtu_slave_link_framer #(.CLK_HZ(1843200)) i_dut (.mclk(mclk), .rst(rst), .rxd_pin(rxd_pin), .txd_pin(txd_pin),
    .tx_en(tx_en), .cfg(cfg), .rd_valid(rd_valid), .rd_req(rd_req), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .cmd_valid(cmd_valid), .cmd(cmd));

  rtu_master_model #(.DIV(DIV)) i_master (.mclk(mclk), .rxd_pin(rxd_pin), .txd_pin(txd_pin), .tx_en(tx_en),
    .par_on(cfg.parity != PAR_NONE), .par_odd(cfg.parity == PAR_ODD));

  // ----------------------------------------
  // word source with bursty stalls, pulse monitors
  // ----------------------------------------
  always @(posedge mclk)
  begin
    if (word_valid && word_ready)
      void'(wq.pop_front());
    if (rd_valid === 1'b1)
      last_rd = rd_req;
    if (cmd_valid === 1'b1)
    begin
      n_cmd++;
      last_cmd = cmd;
    end
    #1;
    stall = stall + 4'h1;
    word_valid = wq.size() > 0 && !stall[3];
    word_data = wq.size() > 0 ? wq[0] : 16'h0000;
  end

  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic wrap_up;
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic transact(input logic [7:0] req[$], input bit bad, input logic [7:0] exp[$]);
    int          t;
    int          g;
    logic [15:0] c;
    g = (DIV * 35 * (cfg.parity == PAR_NONE ? 10 : 11) + 9) / 10;
    i_master.rx_q.delete();
    i_master.send_pkt(req, bad);
    t = 0;
    while (tx_en !== 1'b1 && t < g + 600)
    begin
      @(posedge mclk);
      #1 t++;
    end
    if (exp.size() == 0)
      check(tx_en, 1'b0);
    else
    begin
      check(t > g - DIV && t < g + DIV, 1'b1);
      c = i_master.crc16(exp);
      exp.push_back(c[7:0]);
      exp.push_back(c[15:8]);
      while (tx_en !== 1'b0 && t < 9000)
      begin
        @(posedge mclk);
        #1 t++;
      end
      repeat (2) @(posedge mclk);
      check(i_master.rx_q.size(), exp.size());
      foreach (exp[i])
        check(i_master.rx_q[i], exp[i]);
    end
  endtask : transact

  initial
  begin
    logic [7:0] q[$];
    logic [7:0] e[$];
    int         c0;
    cfg = '{baud_sel: 4'h8, parity: PAR_NONE, slave_addr: 8'h11, front_panel: 1'b0};
    repeat (10) @(posedge mclk);
    #1 check({txd_pin, tx_en, rd_valid, cmd_valid, word_ready}, 5'h10);
    rst = 1'b0;
    foreach (rows[k])
    begin
      #1 cfg.front_panel = rows[k].fp;
      q = {};
      for (int i = 0; i < rows[k].n; i++)
        q.push_back(rows[k].req[71 - 8 * i -: 8]);
      e = {};
      if (rows[k].exc == 8'h00)
        e = q[0:5];
      else if (rows[k].exc != 8'hff)
        e = '{q[0], q[1] | RTU_EXC_FLAG, rows[k].exc};
      c0 = n_cmd;
      transact(q, 1'b0, e);
      check(n_cmd - c0, rows[k].cmd);
      if (rows[k].cmd)
        check({last_cmd.func, last_cmd.arg0, last_cmd.arg1, last_cmd.bcast},
              {q[1], q[2], q[3], q[4], q[5], q[0] == 8'h00});
    end
    for (int p = 1; p < 3; p++)
    begin
      #1 cfg.parity = rtu_parity_t'(p);
      wq = '{16'h0028, 16'h012c, 16'h0000, 16'hbeef};
      q = '{8'h11, 8'h02 + p[7:0], 8'h40, 8'h50, 8'h00, 8'h03};
      transact(q, 1'b0, '{8'h11, q[1], 8'h06, 8'h00, 8'h28, 8'h01, 8'h2c, 8'h00, 8'h00});
      check(last_rd, {q[1], 16'h4050, 16'h0003});
      check(wq.size(), 1);
      check(i_master.frame_bad, 0);
    end
    c0 = n_cmd;
    e = {};
    transact('{8'h11, 8'h05, 8'h00, 8'h01, 8'hff, 8'h00}, 1'b1, e);
    check(n_cmd - c0, 0);
    wrap_up();
  end

  initial
  begin
    // about twice the longest expected run of thirteen transactions
    #360000;
    n_fail++;
    wrap_up();
  end
endmodule : rtu_slave_link_framer_bench

/* File: hdl/rtu_slave_link_framer.sv */
// Purpose : slave end of a half-duplex rtu serial link: framing, filtering, crc, dispatch
// Assumes : cfg and the register-word source sit on mclk; rxd_pin is asynchronous
// Notes   : addressed settings commands are handed out and echoed, broadcast 05h is handed out unanswered; register words come in via a 2-entry buffer

module rtu_slave_link_framer #(
  parameter int unsigned CLK_HZ = rtu_pkg::RTU_CLK_HZ
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               rxd_pin,
  output logic                    txd_pin,
  output logic                    tx_en,
  input  wire rtu_pkg::rtu_cfg_t  cfg,
  output logic                    rd_valid,
  output rtu_pkg::rtu_rdreq_t     rd_req,
  input  wire logic               word_valid,
  output logic                    word_ready,
  input  wire logic [15:0]        word_data,
  output logic                    cmd_valid,
  output rtu_pkg::rtu_cmd_t       cmd
);
  import rtu_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {ST_HUNT, ST_CHECK, ST_SEND, ST_CRCLO, ST_CRCHI, ST_FLUSH} rtu_main_t;
  typedef enum logic [1:0] {RSP_ECHO, RSP_EXC, RSP_READ} rtu_rsp_t;

  typedef struct packed {
    logic                            rs1;
    logic                            rs2;
    logic                            rx_busy;
    logic [23:0]                     rx_cnt;
    logic [3:0]                      rx_bit;
    logic [8:0]                      rx_sh;
    logic [31:0]                     gap_cnt;
    logic [7:0]                      nbytes;
    logic [5:0][7:0]                 hdr;
    logic [15:0]                     rx_crc;
    logic                            rx_bad;
    rtu_main_t                       st;
    rtu_rsp_t                        rsp;
    logic [7:0]                      exc_code;
    logic [2:0]                      idx;
    logic [6:0]                      words_left;
    logic                            lo_half;
    logic [15:0]                     cur_word;
    logic [15:0]                     tx_crc;
    logic                            tx_busy;
    logic [23:0]                     tx_cnt;
    logic [3:0]                      tx_bit;
    logic [10:0]                     tx_sh;
    logic                            txd;
    logic [1:0][15:0]                fifo;
    logic                            wp;
    logic                            rp;
    logic [1:0]                      fcnt;
    logic                            rd_v;
    rtu_rdreq_t                      rd;
    logic                            cmd_v;
    rtu_cmd_t                        cm;
  } rtu_frm_t;

  rtu_frm_t    fr_reg;
  rtu_frm_t    fr_next;
  logic [23:0] div;
  logic [3:0]  nbits;
  logic [31:0] gap_cyc;
  logic        par_en;
  logic        addr_own;
  logic        tx_load;
  logic [7:0]  tx_byte;
  logic        push;
  logic        pop;
  logic        restart;
  logic [15:0] req_cnt;

  // --------------------------------------------------------------------------
  // timing and character shape
  // --------------------------------------------------------------------------
  function automatic logic [23:0] baud_div(input logic [3:0] sel);
    int unsigned rate;
    rate = (sel < RTU_BAUD_CNT) ? RTU_BAUD[sel] : RTU_BAUD[RTU_BAUD_DEF];
    return 24'(CLK_HZ / rate);
  endfunction : baud_div

  function automatic logic [10:0] char_frame(input logic [7:0] b, input rtu_parity_t p);
    logic pb;
    pb = (^b) ^ (p == PAR_ODD);
    return (p == PAR_NONE) ? {2'b11, b, 1'b0} : {1'b1, pb, b, 1'b0};
  endfunction : char_frame

  assign div     = baud_div(cfg.baud_sel);
  assign par_en  = (cfg.parity != PAR_NONE);
  assign nbits   = par_en ? RTU_BITS_PAR : RTU_BITS_NOPAR;
  // 3.5 characters in half-character units, rounded up to whole cycles
  assign gap_cyc = 32'((32'(div) * RTU_GAP_HALF_CHARS * 32'(nbits) + 32'h1) >> 1);
  assign req_cnt = {fr_reg.hdr[4], fr_reg.hdr[5]};
  // take no more words than the reply still owes, so none is left over to leak into the next read
  assign word_ready = (fr_reg.st == ST_SEND) && (fr_reg.rsp == RSP_READ) && (fr_reg.fcnt != RTU_BUF_DEPTH)
                      && (({5'h00, fr_reg.fcnt} + {6'h00, fr_reg.lo_half}) < fr_reg.words_left);
  assign push    = word_valid && word_ready;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    fr_next       = fr_reg;
    fr_next.rs1   = rxd_pin;
    fr_next.rs2   = fr_reg.rs1;
    fr_next.rd_v  = 1'b0;
    fr_next.cmd_v = 1'b0;
    tx_load       = 1'b0;
    tx_byte       = 8'h00;
    pop           = 1'b0;
    restart       = 1'b0;
    addr_own      = cfg.front_panel
                    || (fr_reg.hdr[0] == cfg.slave_addr
                        && cfg.slave_addr >= RTU_ADDR_MIN && cfg.slave_addr <= RTU_ADDR_MAX);

    // receiver: mid-bit sampling, gap timer runs only while the line rests
    if (!fr_reg.rx_busy)
    begin
      if (fr_reg.gap_cnt != '1)
        fr_next.gap_cnt = fr_reg.gap_cnt + 32'h1;
      if (!fr_reg.rs2)
      begin
        fr_next.rx_busy = 1'b1;
        fr_next.rx_cnt  = div >> 1;
        fr_next.rx_bit  = 4'h0;
      end
    end
    else
    begin
      fr_next.gap_cnt = '0;
      if (fr_reg.rx_cnt != 24'h000000)
        fr_next.rx_cnt = fr_reg.rx_cnt - 24'h000001;
      else
      begin
        fr_next.rx_cnt = div - 24'h000001;
        fr_next.rx_bit = fr_reg.rx_bit + 4'h1;
        if (fr_reg.rx_bit == 4'h0)
        begin
          // a start bit that is high again at mid-bit was a glitch
          if (fr_reg.rs2)
            fr_next.rx_busy = 1'b0;
        end
        else if (fr_reg.rx_bit <= 4'h8)
          fr_next.rx_sh[7:0] = {fr_reg.rs2, fr_reg.rx_sh[7:1]};
        else if (fr_reg.rx_bit == 4'h9 && par_en)
          fr_next.rx_sh[8] = fr_reg.rs2;
        else
        begin
          fr_next.rx_busy = 1'b0;
          // bytes arriving while we answer are dropped: the line is half duplex
          if (fr_reg.st == ST_HUNT)
          begin
            if (fr_reg.nbytes < RTU_HDR_BYTES)
              fr_next.hdr[fr_reg.nbytes[2:0]] = fr_reg.rx_sh[7:0];
            fr_next.rx_crc = rtu_crc_byte(fr_reg.rx_crc, fr_reg.rx_sh[7:0]);
            if (fr_reg.nbytes != 8'hff)
              fr_next.nbytes = fr_reg.nbytes + 8'h01;
            fr_next.rx_bad = fr_reg.rx_bad || !fr_reg.rs2
                             || (par_en && ((^fr_reg.rx_sh) ^ (cfg.parity == PAR_ODD)));
          end
        end
      end
    end

    // transmitter: shifts one character, line high when idle
    if (fr_reg.tx_busy)
    begin
      if (fr_reg.tx_cnt != 24'h000000)
        fr_next.tx_cnt = fr_reg.tx_cnt - 24'h000001;
      else if (fr_reg.tx_bit == 4'h0)
        fr_next.tx_busy = 1'b0;
      else
      begin
        fr_next.tx_cnt = div - 24'h000001;
        fr_next.tx_bit = fr_reg.tx_bit - 4'h1;
        fr_next.tx_sh  = fr_reg.tx_sh >> 1;
        fr_next.txd    = fr_reg.tx_sh[1];
      end
    end

    // packet handling
    unique case (fr_reg.st)
      ST_HUNT:
        if (!fr_reg.rx_busy && fr_reg.nbytes != 8'h00 && fr_reg.gap_cnt >= gap_cyc)
          fr_next.st = ST_CHECK;
      ST_CHECK:
      begin
        fr_next.idx      = 3'h0;
        fr_next.lo_half  = 1'b0;
        fr_next.tx_crc   = RTU_CRC_INIT;
        fr_next.st       = ST_SEND;
        fr_next.rsp      = RSP_ECHO;
        fr_next.cm.func  = fr_reg.hdr[1];
        fr_next.cm.arg0  = {fr_reg.hdr[2], fr_reg.hdr[3]};
        fr_next.cm.arg1  = req_cnt;
        fr_next.cm.bcast = 1'b0;
        if (fr_reg.rx_bad || fr_reg.rx_crc != 16'h0000 || fr_reg.nbytes < RTU_MIN_FRAME)
          restart = 1'b1;
        else if (fr_reg.hdr[0] == RTU_BCAST)
        begin
          restart = 1'b1;
          if (fr_reg.hdr[1] == FC_EXEC && fr_reg.nbytes == RTU_FIXED_FRAME)
          begin
            fr_next.cmd_v    = 1'b1;
            fr_next.cm.bcast = 1'b1;
          end
        end
        else if (!addr_own)
          restart = 1'b1;
        else
        begin
          unique case (fr_reg.hdr[1])
            FC_RD_HOLD, FC_RD_INPUT:
              if (fr_reg.nbytes == RTU_FIXED_FRAME && req_cnt != 16'h0000 && req_cnt <= RTU_MAX_READ)
              begin
                fr_next.rsp        = RSP_READ;
                fr_next.rd_v       = 1'b1;
                fr_next.rd.func    = fr_reg.hdr[1];
                fr_next.rd.start   = {fr_reg.hdr[2], fr_reg.hdr[3]};
                fr_next.rd.count   = req_cnt;
                fr_next.words_left = req_cnt[6:0];
              end
              else
              begin
                fr_next.rsp      = RSP_EXC;
                fr_next.exc_code = RTU_ERR_VALUE;
              end
            FC_EXEC, FC_STORE_ONE, FC_STORE_MANY:
              if (fr_reg.nbytes >= RTU_FIXED_FRAME)
                fr_next.cmd_v = 1'b1;
              else
              begin
                fr_next.rsp      = RSP_EXC;
                fr_next.exc_code = RTU_ERR_VALUE;
              end
            default:
            begin
              fr_next.rsp      = RSP_EXC;
              fr_next.exc_code = RTU_ERR_FUNC;
            end
          endcase
        end
      end
      ST_SEND:
        if (!fr_reg.tx_busy)
        begin
          if (fr_reg.idx < ((fr_reg.rsp == RSP_ECHO) ? RTU_ECHO_LEN : RTU_SHORT_LEN))
          begin
            tx_load     = 1'b1;
            fr_next.idx = fr_reg.idx + 3'h1;
            unique case (fr_reg.idx)
              3'h1:
                tx_byte = (fr_reg.rsp == RSP_EXC) ? (fr_reg.hdr[1] | RTU_EXC_FLAG) : fr_reg.hdr[1];
              3'h2:
                tx_byte = (fr_reg.rsp == RSP_EXC)  ? fr_reg.exc_code :
                          (fr_reg.rsp == RSP_READ) ? {fr_reg.rd.count[6:0], 1'b0} : fr_reg.hdr[2];
              default:
                tx_byte = fr_reg.hdr[fr_reg.idx];
            endcase
          end
          else if (fr_reg.rsp == RSP_READ && fr_reg.words_left != 7'h00)
          begin
            if (fr_reg.lo_half)
            begin
              tx_load            = 1'b1;
              tx_byte            = fr_reg.cur_word[7:0];
              fr_next.lo_half    = 1'b0;
              fr_next.words_left = fr_reg.words_left - 7'h01;
            end
            else if (fr_reg.fcnt != 2'h0)
            begin
              // high byte first; a late word source simply stretches the gap
              pop              = 1'b1;
              tx_load          = 1'b1;
              tx_byte          = fr_reg.fifo[fr_reg.rp][15:8];
              fr_next.cur_word = fr_reg.fifo[fr_reg.rp];
              fr_next.lo_half  = 1'b1;
            end
          end
          else
            fr_next.st = ST_CRCLO;
        end
      ST_CRCLO:
        if (!fr_reg.tx_busy)
        begin
          tx_load    = 1'b1;
          tx_byte    = fr_reg.tx_crc[7:0];
          fr_next.st = ST_CRCHI;
        end
      ST_CRCHI:
        if (!fr_reg.tx_busy)
        begin
          tx_load    = 1'b1;
          tx_byte    = fr_reg.tx_crc[15:8];
          fr_next.st = ST_FLUSH;
        end
      ST_FLUSH:
        if (!fr_reg.tx_busy)
          restart = 1'b1;
    endcase

    if (tx_load)
    begin
      fr_next.tx_busy = 1'b1;
      fr_next.tx_sh   = char_frame(tx_byte, cfg.parity);
      fr_next.txd     = 1'b0;
      fr_next.tx_cnt  = div - 24'h000001;
      fr_next.tx_bit  = nbits - 4'h1;
      if (fr_reg.st == ST_SEND)
        fr_next.tx_crc = rtu_crc_byte(fr_reg.tx_crc, tx_byte);
    end

    if (restart)
    begin
      fr_next.st     = ST_HUNT;
      fr_next.nbytes = 8'h00;
      fr_next.rx_crc = RTU_CRC_INIT;
      fr_next.rx_bad = 1'b0;
    end

    // two-entry word buffer
    if (push)
    begin
      fr_next.fifo[fr_reg.wp] = word_data;
      fr_next.wp              = ~fr_reg.wp;
    end
    if (pop)
      fr_next.rp = ~fr_reg.rp;
    fr_next.fcnt = fr_reg.fcnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      fr_reg        <= '0;
      fr_reg.rs1    <= 1'b1;
      fr_reg.rs2    <= 1'b1;
      fr_reg.rx_crc <= RTU_CRC_INIT;
      fr_reg.tx_crc <= RTU_CRC_INIT;
      fr_reg.txd    <= 1'b1;
    end
    else
      fr_reg <= fr_next;
  end

  assign txd_pin   = fr_reg.txd;
  assign tx_en     = (fr_reg.st == ST_SEND) || (fr_reg.st == ST_CRCLO) || (fr_reg.st == ST_CRCHI)
                     || (fr_reg.st == ST_FLUSH);
  assign rd_valid  = fr_reg.rd_v;
  assign rd_req    = fr_reg.rd;
  assign cmd_valid = fr_reg.cmd_v;
  assign cmd       = fr_reg.cm;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  property p_bcast_quiet;
    @(posedge mclk) disable iff (rst)
    (fr_reg.st == ST_CHECK && fr_reg.hdr[0] == RTU_BCAST) |=> (fr_reg.st == ST_HUNT && !rd_valid);
  endproperty
  a_bcast_quiet: assert property (p_bcast_quiet)
    else $error("broadcast request drew a response");

  property p_crc_drop;
    @(posedge mclk) disable iff (rst)
    (fr_reg.st == ST_CHECK && fr_reg.rx_crc != 16'h0000) |=> (fr_reg.st == ST_HUNT && !cmd_valid && !rd_valid);
  endproperty
  a_crc_drop: assert property (p_crc_drop)
    else $error("packet with bad crc was acted on");

  property p_rd_limit;
    @(posedge mclk) disable iff (rst)
    rd_valid |-> (rd_req.count != 16'h0000 && rd_req.count <= RTU_MAX_READ && fr_reg.st == ST_SEND);
  endproperty
  a_rd_limit: assert property (p_rd_limit)
    else $error("read request outside 1 to 125 registers");

  property p_bcast_func;
    @(posedge mclk) disable iff (rst)
    (cmd_valid && cmd.bcast) |-> (cmd.func == FC_EXEC && fr_reg.st == ST_HUNT);
  endproperty
  a_bcast_func: assert property (p_bcast_func)
    else $error("broadcast accepted with a function other than 05h");

  property p_start_bit;
    @(posedge mclk) disable iff (rst)
    tx_load |=> (!txd_pin && tx_en);
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("character did not open with a low start bit");

  property p_quiet_hunt;
    @(posedge mclk) disable iff (rst)
    (fr_reg.st == ST_HUNT) |-> (txd_pin && !tx_en && !fr_reg.tx_busy);
  endproperty
  a_quiet_hunt: assert property (p_quiet_hunt)
    else $error("line driven while no request is being answered");

  property p_exc_flag;
    @(posedge mclk) disable iff (rst)
    (tx_load && fr_reg.rsp == RSP_EXC && fr_reg.st == ST_SEND && fr_reg.idx == 3'h1) |-> tx_byte[7];
  endproperty
  a_exc_flag: assert property (p_exc_flag)
    else $error("exception function code lacks its top bit");

  property p_addr_match;
    @(posedge mclk) disable iff (rst)
    rd_valid |-> $past(addr_own);
  endproperty
  a_addr_match: assert property (p_addr_match)
    else $error("read issued for a foreign slave address");

  property p_crc_lo;
    @(posedge mclk) disable iff (rst)
    (fr_reg.st == ST_CRCLO && tx_load) |-> (tx_byte == fr_reg.tx_crc[7:0]) ##1 (fr_reg.st == ST_CRCHI);
  endproperty
  a_crc_lo: assert property (p_crc_lo)
    else $error("crc not sent low byte first");

endmodule : rtu_slave_link_framer

/* File: inc/rtu_pkg.sv */
// Purpose : shared constants, types and crc step for the rtu slave framer
// Assumes : one device clock, 8-bit characters on an asynchronous line
// Notes   : timing counts are derived inside the framer from its clock parameter

// ----------------------------------------------------------------------------
// package
// ----------------------------------------------------------------------------
package rtu_pkg;

  localparam int unsigned RTU_CLK_HZ         = 250_000_000;
  localparam int unsigned RTU_BAUD [9]       = '{300, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  localparam logic [3:0]  RTU_BAUD_CNT       = 4'h9;
  localparam logic [3:0]  RTU_BAUD_DEF       = 4'h5;
  localparam int unsigned RTU_GAP_HALF_CHARS = 7;
  localparam logic [3:0]  RTU_BITS_NOPAR     = 4'ha;
  localparam logic [3:0]  RTU_BITS_PAR       = 4'hb;

  localparam logic [7:0]  RTU_BCAST          = 8'h00;
  localparam logic [7:0]  RTU_ADDR_MIN       = 8'h01;
  localparam logic [7:0]  RTU_ADDR_MAX       = 8'hfe;
  localparam logic [7:0]  FC_RD_HOLD         = 8'h03;
  localparam logic [7:0]  FC_RD_INPUT        = 8'h04;
  localparam logic [7:0]  FC_EXEC            = 8'h05;
  localparam logic [7:0]  FC_STORE_ONE       = 8'h06;
  localparam logic [7:0]  FC_STORE_MANY      = 8'h10;
  localparam logic [7:0]  RTU_EXC_FLAG       = 8'h80;
  localparam logic [7:0]  RTU_ERR_FUNC       = 8'h01;
  localparam logic [7:0]  RTU_ERR_VALUE      = 8'h03;

  localparam logic [15:0] RTU_CRC_INIT       = 16'hffff;
  localparam logic [15:0] RTU_CRC_POLY       = 16'ha001;
  localparam logic [15:0] RTU_MAX_READ       = 16'h007d;
  localparam logic [7:0]  RTU_MIN_FRAME      = 8'h04;
  localparam logic [7:0]  RTU_FIXED_FRAME    = 8'h08;
  localparam logic [7:0]  RTU_HDR_BYTES      = 8'h06;
  localparam logic [2:0]  RTU_ECHO_LEN       = 3'h6;
  localparam logic [2:0]  RTU_SHORT_LEN      = 3'h3;
  localparam logic [1:0]  RTU_BUF_DEPTH      = 2'h2;

  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} rtu_parity_t;

  typedef struct packed {
    logic [3:0]  baud_sel;
    rtu_parity_t parity;
    logic [7:0]  slave_addr;
    logic        front_panel;
  } rtu_cfg_t;

  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] start;
    logic [15:0] count;
  } rtu_rdreq_t;

  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] arg0;
    logic [15:0] arg1;
    logic        bcast;
  } rtu_cmd_t;

  function automatic logic [15:0] rtu_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ RTU_CRC_POLY) : (c >> 1);
    return c;
  endfunction : rtu_crc_byte

endpackage : rtu_pkg
